// ### hdl/rom_wait_timer.sv
// Counter that stretches a ROM read bus cycle by the programmed waits
`timescale 1ns/10ps
module rom_wait_timer
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic start,
   input wire logic [1:0] waits,
   output logic done
);

   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic busy_r;
   logic busy_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      busy_nxt = busy_r;
      done = 1'b0;
      if (!busy_r && start)
      begin
         if (waits == 2'h0)
            done = 1'b1;
         else
         begin
            busy_nxt = 1'b1;
            cnt_nxt = waits;
         end
      end
      else if (busy_r)
      begin
         // One extra clock per wait
         cnt_nxt = cnt_r - 2'h1;
         if (cnt_r == 2'h1)
         begin
            busy_nxt = 1'b0;
            done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= 2'h0;
         busy_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

endmodule : rom_wait_timer

// ### hdl/system_bus_access_control.sv
// Bus bridge between CPU data port and internal memories and peripherals
`timescale 1ns/10ps
module system_bus_access_control
(
   input wire logic mclk,
   input wire logic resetn,
   input wire bus_ctl_pkg::cpu_req_t cpu_req,
   output logic cpu_ack,
   output logic [31:0] cpu_rdata,
   input wire logic [23:0] fetch_addr,
   input wire logic fetch_req,
   output logic fetch_stall,
   input wire logic [7:0] processor_status_flags,
   output bus_ctl_pkg::bus_cyc_t bus_out,
   input wire logic [31:0] bus_rdata,
   output logic [1:0] rom_wait_count,
   output logic [23:0] vector_base
);

   typedef enum logic [1:0] {st_idle, st_cycle, st_wait} state_t;

   state_t state_r, state_nxt;
   logic [1:0] part_r, part_nxt;
   logic [1:0] parts_r, parts_nxt;
   bus_ctl_pkg::cpu_req_t req_r, req_nxt;
   logic [31:0] acc_r, acc_nxt;
   logic [1:0] wl_r, wl_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic [15:0] vbl_r, vbl_nxt;
   logic [7:0] vbh_r, vbh_nxt;
   bus_ctl_pkg::bus_cyc_t cyc_nxt;
   logic [31:0] rdata_nxt;
   logic ack_nxt;
   logic wait_start;
   logic wait_done;
   logic [23:0] part_addr;
   logic [4:0] shift;
   logic [31:0] lane_mask;
   logic [31:0] wr_word;
   logic [1:0] sz;
   logic [1:0] w;
   logic is_rom_rd;
   logic [31:0] got;

   rom_wait_timer u_wait
   (
      .mclk(mclk),
      .resetn(resetn),
      .start(wait_start),
      .waits(wait_r),
      .done(wait_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Part address and byte lanes of the current bus cycle

   always_comb
   begin
      // Ascending addresses, lowest bytes first
      part_addr = req_r.addr + 24'((32'(part_r)) << wl_r);
      shift = 5'((32'(part_r) << wl_r) * 8);
      case (wl_r)
         2'h0: lane_mask = 32'h000000FF;
         2'h1: lane_mask = 32'h0000FFFF;
         default: lane_mask = 32'hFFFFFFFF;
      endcase
      // Stack pushes keep the flags in the top byte; plain 32-bit writes zero it
      if (req_r.size == bus_ctl_pkg::size_32 && !req_r.stack)
         wr_word = {8'h00, req_r.wdata[23:0]};
      else if (req_r.stack)
         wr_word = {processor_status_flags, req_r.wdata[23:0]};
      else
         wr_word = req_r.wdata;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer

   always_comb
   begin
      state_nxt = state_r;
      part_nxt = part_r;
      parts_nxt = parts_r;
      req_nxt = req_r;
      acc_nxt = acc_r;
      wl_nxt = wl_r;
      wait_nxt = wait_r;
      vbl_nxt = vbl_r;
      vbh_nxt = vbh_r;
      cyc_nxt = '0;
      rdata_nxt = cpu_rdata;
      ack_nxt = 1'b0;
      wait_start = 1'b0;
      sz = (cpu_req.size == bus_ctl_pkg::size_8) ? 2'h0 :
           (cpu_req.size == bus_ctl_pkg::size_16) ? 2'h1 : 2'h2;
      w = bus_ctl_pkg::dev_width(cpu_req.addr);
      if (w > sz)
         w = sz;
      is_rom_rd = !req_r.write && bus_ctl_pkg::decode(part_addr) == bus_ctl_pkg::rgn_rom;
      got = (bus_rdata & lane_mask) << shift;
      unique case (state_r)
         st_idle:
         begin
            // Request still stands in the ack cycle; taking it then would repeat it
            if (cpu_req.valid && !cpu_ack)
            begin
               req_nxt = cpu_req;
               wl_nxt = w;
               // 2 or 4 cycles when wider than the target
               parts_nxt = 2'(((32'h1) << (sz - w)) - 32'h1);
               part_nxt = 2'h0;
               acc_nxt = '0;
               state_nxt = st_cycle;
            end
         end
         st_cycle:
         begin
            // One system clock per cycle
            cyc_nxt.valid = 1'b1;
            cyc_nxt.write = req_r.write;
            cyc_nxt.region = bus_ctl_pkg::decode(part_addr);
            cyc_nxt.addr = part_addr;
            cyc_nxt.width_log = wl_r;
            cyc_nxt.wdata = (wr_word >> shift) & lane_mask;
            if (is_rom_rd && wait_r != 2'h0)
            begin
               wait_start = 1'b1;
               state_nxt = st_wait;
               acc_nxt = acc_r | got;
            end
            else
            begin
               acc_nxt = acc_r | got;
               if (req_r.write)
               begin
                  if (part_addr == bus_ctl_pkg::rom_wait_register_addr)
                     wait_nxt = req_r.wdata[bus_ctl_pkg::rom_wait_lsb +: 2];
                  if (part_addr == bus_ctl_pkg::vector_base_low_addr)
                     vbl_nxt = req_r.wdata[15:0] & 16'hFF00;
                  if (part_addr == bus_ctl_pkg::vector_base_high_addr)
                     vbh_nxt = req_r.wdata[7:0];
               end
               else if (part_addr == bus_ctl_pkg::rom_wait_register_addr)
                  acc_nxt = acc_r | (32'(wait_r) << shift);
               if (part_r == parts_r)
               begin
                  ack_nxt = 1'b1;
                  state_nxt = st_idle;
                  // Drop the top byte unless popping a stack frame
                  if (req_r.size == bus_ctl_pkg::size_32 && !req_r.stack)
                     rdata_nxt = {8'h00, acc_nxt[23:0]};
                  else
                     rdata_nxt = acc_nxt;
               end
               else
                  part_nxt = part_r + 2'h1;
            end
         end
         st_wait:
         begin
            if (wait_done)
            begin
               if (part_r == parts_r)
               begin
                  ack_nxt = 1'b1;
                  state_nxt = st_idle;
                  rdata_nxt = (req_r.size == bus_ctl_pkg::size_32 && !req_r.stack) ?
                              {8'h00, acc_r[23:0]} : acc_r;
               end
               else
               begin
                  part_nxt = part_r + 2'h1;
                  state_nxt = st_cycle;
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= st_idle;
         part_r <= 2'h0;
         parts_r <= 2'h0;
         req_r <= '0;
         acc_r <= 32'h00000000;
         wl_r <= 2'h0;
         wait_r <= bus_ctl_pkg::rom_wait_reset;
         vbl_r <= bus_ctl_pkg::vector_base_reset[15:0];
         vbh_r <= bus_ctl_pkg::vector_base_reset[23:16];
         bus_out <= '0;
         cpu_rdata <= 32'h00000000;
         cpu_ack <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         part_r <= part_nxt;
         parts_r <= parts_nxt;
         req_r <= req_nxt;
         acc_r <= acc_nxt;
         wl_r <= wl_nxt;
         wait_r <= wait_nxt;
         vbl_r <= vbl_nxt;
         vbh_r <= vbh_nxt;
         bus_out <= cyc_nxt;
         cpu_rdata <= rdata_nxt;
         cpu_ack <= ack_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fetch arbitration and register outputs

   always_comb
   begin
      bus_ctl_pkg::region_t fr;
      fr = bus_ctl_pkg::decode(fetch_addr);
      // Same memory for code and data: fetch waits out the data cycles
      fetch_stall = fetch_req && state_r != st_idle &&
                    (fr == bus_ctl_pkg::rgn_rom || fr == bus_ctl_pkg::rgn_ram) &&
                    fr == bus_ctl_pkg::decode(part_addr);
   end

   assign rom_wait_count = wait_r;
   assign vector_base = {vbh_r, vbl_r};

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_wait_reset: assert property (@(posedge mclk) $rose(resetn) |-> wait_r == 2'h3)
      else $error("rom wait not three after reset");
   a_rom_decode: assert property (@(posedge mclk) disable iff (!resetn)
      bus_out.valid && bus_out.addr >= 24'h008000 && bus_out.addr <= 24'h00BFFF
      |-> bus_out.region == bus_ctl_pkg::rgn_rom)
      else $error("rom address not decoded as rom");
   a_ram_decode: assert property (@(posedge mclk) disable iff (!resetn)
      bus_out.valid && bus_out.addr <= 24'h0007FF |-> bus_out.region == bus_ctl_pkg::rgn_ram)
      else $error("ram address not decoded as ram");
   a_core_decode: assert property (@(posedge mclk) disable iff (!resetn)
      bus_out.valid && bus_out.addr >= 24'hFFFC00 |-> bus_out.region == bus_ctl_pkg::rgn_core)
      else $error("core io not decoded");
   a_split_four: assert property (@(posedge mclk) disable iff (!resetn)
      state_r == st_idle && cpu_req.valid && !cpu_ack && cpu_req.size == bus_ctl_pkg::size_32 &&
      bus_ctl_pkg::dev_width(cpu_req.addr) == 2'h0 |=> parts_r == 2'h3)
      else $error("32-bit to 8-bit target not four cycles");
   a_write_top: assert property (@(posedge mclk) disable iff (!resetn)
      bus_out.valid && bus_out.write && bus_out.width_log == 2'h2 && !req_r.stack
      |-> bus_out.wdata[31:24] == 8'h00)
      else $error("upper byte written nonzero");
   a_read_top: assert property (@(posedge mclk) disable iff (!resetn)
      cpu_ack && !req_r.write && req_r.size == bus_ctl_pkg::size_32 && !req_r.stack
      |-> cpu_rdata[31:24] == 8'h00)
      else $error("upper read byte delivered");
   a_one_clock: assert property (@(posedge mclk) disable iff (!resetn)
      state_r == st_idle && cpu_req.valid && !cpu_ack && cpu_req.size == bus_ctl_pkg::size_8 &&
      bus_ctl_pkg::decode(cpu_req.addr) == bus_ctl_pkg::rgn_ram |-> ##2 cpu_ack)
      else $error("single ram cycle not one clock");
   a_rom_waits: assert property (@(posedge mclk) disable iff (!resetn)
      state_r == st_cycle && wait_start && wait_r == 2'h2 && part_r == parts_r
      |-> ##2 ack_nxt)
      else $error("two waits not two extra clocks");
   a_fetch_hold: assert property (@(posedge mclk) disable iff (!resetn)
      fetch_req && state_r == st_idle |-> !fetch_stall)
      else $error("fetch stalled with no data access");

   c_split: cover property (@(posedge mclk) parts_r == 2'h3 && cpu_ack);
   c_waited: cover property (@(posedge mclk) state_r == st_wait);
   c_stall: cover property (@(posedge mclk) fetch_stall);

endmodule : system_bus_access_control

// ### include/bus_ctl_pkg.sv
// Package of address map, widths, register layout and types for the bus bridge
package bus_ctl_pkg;

   localparam logic [23:0] ram_base = 24'h000000;
   localparam logic [23:0] ram_last = 24'h0007FF;
   localparam logic [23:0] per1_base = 24'h004000;
   localparam logic [23:0] per1_last = 24'h0043FF;
   localparam logic [23:0] per2_base = 24'h005000;
   localparam logic [23:0] per2_last = 24'h005FFF;
   localparam logic [23:0] rom_base = 24'h008000;
   localparam logic [23:0] rom_last = 24'h00BFFF;
   localparam logic [23:0] core_io_base = 24'hFFFC00;
   localparam logic [23:0] core_io_last = 24'hFFFFFF;
   localparam logic [23:0] seg_base = 24'h0053C0;
   localparam logic [23:0] seg_last = 24'h0053DF;
   localparam logic [23:0] rom_wait_register_addr = 24'h0054B0;
   localparam logic [23:0] vector_base_low_addr = 24'h005328;
   localparam logic [23:0] vector_base_high_addr = 24'h00532A;
   localparam logic [1:0] rom_wait_reset = 2'h3;
   localparam logic [23:0] vector_base_reset = 24'h008000;
   localparam int rom_wait_lsb = 0;
   localparam int vbh_bits = 8;
   localparam int sys_clk_ns = 8;

   typedef enum logic [1:0] {size_8, size_16, size_32} acc_size_t;
   typedef enum logic [2:0] {rgn_none, rgn_ram, rgn_rom, rgn_per, rgn_core} region_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic stack;
      acc_size_t size;
      logic [23:0] addr;
      logic [31:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic valid;
      logic write;
      region_t region;
      logic [23:0] addr;
      logic [1:0] width_log;
      logic [31:0] wdata;
   } bus_cyc_t;

   // Region decode, also used for instruction fetch comparison
   function automatic region_t decode(input logic [23:0] a);
      if (a <= ram_last) return rgn_ram;
      if (a >= rom_base && a <= rom_last) return rgn_rom;
      if ((a >= per1_base && a <= per1_last) || (a >= per2_base && a <= per2_last))
         return rgn_per;
      if (a >= core_io_base) return rgn_core;
      return rgn_none;
   endfunction : decode

   // Target device width as log2 of bytes
   function automatic logic [1:0] dev_width(input logic [23:0] a);
      region_t r;
      r = decode(a);
      if (r == rgn_ram) return 2'h2;
      if (r == rgn_rom) return 2'h1;
      if (r == rgn_per)
      begin
         if (a >= seg_base && a <= seg_last) return 2'h1;
         if ((a >= 24'h004100 && a <= 24'h00411F) || (a >= 24'h004020 && a <= 24'h00403F))
            return 2'h0;
         if (a >= per2_base && a < 24'h005320) return 2'h0;
         return 2'h1;
      end
      return 2'h0;
   endfunction : dev_width

endpackage : bus_ctl_pkg

// ### tb/cpu_model.sv
// Model of the CPU core that issues data accesses and instruction fetches
`timescale 1ns/10ps
module cpu_model
(
   input wire logic mclk,
   output bus_ctl_pkg::cpu_req_t cpu_req,
   input wire logic cpu_ack,
   input wire logic [31:0] cpu_rdata,
   output logic [23:0] fetch_addr,
   output logic fetch_req,
   output logic [7:0] processor_status_flags
);
   initial
   begin
      cpu_req = '0;
      fetch_addr = 24'h008000;
      fetch_req = 1'b0;
      processor_status_flags = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Request stands until the edge that samples the ack, then drops at that edge
   task automatic access(input logic [23:0] a, input bus_ctl_pkg::acc_size_t s,
      input logic w, input logic st, input logic [31:0] d, output logic [31:0] rd,
      output int lat);
      int n;
      n = 0;
      @(posedge mclk);
      cpu_req <= '{valid: 1'b1, write: w, stack: st, size: s, addr: a, wdata: d};
      processor_status_flags <= st ? d[31:24] : 8'h00;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (cpu_ack !== 1'b1 && n < 60);
      rd = cpu_rdata;
      cpu_req.valid <= 1'b0;
      lat = n - 1;
   endtask : access

   task automatic set_fetch(input logic [23:0] a, input logic r);
      @(posedge mclk);
      fetch_addr <= a;
      fetch_req <= r;
   endtask : set_fetch
endmodule : cpu_model

// ### tb/system_bus_access_control_tb.sv
// Self-checking bench for the bus bridge
`timescale 1ns/10ps
module system_bus_access_control_tb;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   bus_ctl_pkg::cpu_req_t cpu_req;
   bus_ctl_pkg::bus_cyc_t bus_out;
   logic cpu_ack, fetch_req, fetch_stall, stall_seen;
   logic [31:0] cpu_rdata, rd;
   logic [31:0] bus_rdata = 32'hA5C39E71;
   logic [23:0] fetch_addr, vector_base;
   logic [7:0] processor_status_flags;
   logic [1:0] rom_wait_count;
   logic [23:0] part_q[$];
   logic [31:0] wd_q[$];
   bus_ctl_pkg::region_t rg_q[$];
   int lat;
   int error_cnt = 0;
   int total_checks = 0;

   always #4 mclk = ~mclk;

   system_bus_access_control DUT (.mclk(mclk), .resetn(resetn), .cpu_req(cpu_req),
      .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .fetch_addr(fetch_addr),
      .fetch_req(fetch_req), .fetch_stall(fetch_stall),
      .processor_status_flags(processor_status_flags), .bus_out(bus_out),
      .bus_rdata(bus_rdata), .rom_wait_count(rom_wait_count), .vector_base(vector_base));

   cpu_model cpu (.mclk(mclk), .cpu_req(cpu_req), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
      .fetch_addr(fetch_addr), .fetch_req(fetch_req),
      .processor_status_flags(processor_status_flags));

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycle monitor; the memory side answers with one fixed word
   always @(posedge mclk)
   begin
      if (bus_out.valid === 1'b1)
      begin
         part_q.push_back(bus_out.addr);
         wd_q.push_back(bus_out.wdata);
         rg_q.push_back(bus_out.region);
      end
      if (fetch_stall === 1'b1)
         stall_seen = 1'b1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic acc(input logic [23:0] a, input logic [1:0] s, input logic w,
      input logic st, input logic [31:0] d);
      part_q.delete();
      wd_q.delete();
      rg_q.delete();
      stall_seen = 1'b0;
      cpu.access(a, bus_ctl_pkg::acc_size_t'(s), w, st, d, rd, lat);
      @(negedge mclk);
   endtask : acc

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(32'(rom_wait_count), 32'h3);
      check(32'(vector_base), 32'h008000);
      check(32'(cpu_ack), 32'h0);
      $display("test reset done");
   endtask : t_reset

   // Every wait setting, read back, then timed on a ROM read
   task automatic t_waits();
      for (int w = 0; w < 4; w++)
      begin
         acc(bus_ctl_pkg::rom_wait_register_addr, 2'h1, 1'b1, 1'b0, 32'(w));
         acc(bus_ctl_pkg::rom_wait_register_addr, 2'h1, 1'b0, 1'b0, 32'h0);
         check(32'(rd[1:0]), 32'(w));
         check(32'(rom_wait_count), 32'(w));
         acc(24'h008002, 2'h1, 1'b0, 1'b0, 32'h0);
         check(32'(lat), 32'(2 + w));
      end
      acc(bus_ctl_pkg::rom_wait_register_addr, 2'h1, 1'b1, 1'b0, 32'h0);
      $display("test waits done");
   endtask : t_waits

   // Part counts, order, latency and region across the map, one unmapped hole
   task automatic t_split();
      logic [23:0] ta[8] = '{24'h000010, 24'h008004, 24'h004240, 24'h005000,
         24'h005000, 24'h0053C0, 24'hFFFC00, 24'h001000};
      logic [1:0] ts[8] = '{2'h2, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
      int tp[8] = '{1, 2, 2, 2, 4, 1, 1, 1};
      bus_ctl_pkg::region_t tr[8] = '{bus_ctl_pkg::rgn_ram, bus_ctl_pkg::rgn_rom,
         bus_ctl_pkg::rgn_per, bus_ctl_pkg::rgn_per, bus_ctl_pkg::rgn_per,
         bus_ctl_pkg::rgn_per, bus_ctl_pkg::rgn_core, bus_ctl_pkg::rgn_none};
      int step;
      for (int i = 0; i < 8; i++)
      begin
         acc(ta[i], ts[i], 1'b0, 1'b0, 32'h0);
         step = (1 << ts[i]) / tp[i];
         check(32'(part_q.size()), 32'(tp[i]));
         check(32'(lat), 32'(tp[i] + 1));
         check(32'(rg_q[0]), 32'(tr[i]));
         for (int k = 0; k < tp[i]; k++)
            check(32'(part_q[k]), 32'(ta[i] + 24'(k * step)));
      end
      $display("test split done");
   endtask : t_split

   task automatic t_wide();
      acc(24'h000020, 2'h2, 1'b1, 1'b0, 32'hFFEEDDCC);
      check(wd_q[0], 32'h00EEDDCC);
      acc(24'h000020, 2'h2, 1'b0, 1'b0, 32'h0);
      check(rd, 32'h00C39E71);
      acc(24'h000024, 2'h2, 1'b1, 1'b1, 32'h9A123456);
      check(wd_q[0], 32'h9A123456);
      acc(24'h000024, 2'h2, 1'b0, 1'b1, 32'h0);
      check(rd, 32'hA5C39E71);
      acc(24'h005000, 2'h2, 1'b1, 1'b0, 32'hFF332211);
      check(wd_q[0], 32'h00000011);
      check(wd_q[1], 32'h00000022);
      check(wd_q[2], 32'h00000033);
      check(wd_q[3], 32'h00000000);
      acc(24'h005000, 2'h2, 1'b0, 1'b0, 32'h0);
      check(rd, 32'h00717171);
      $display("test wide done");
   endtask : t_wide

   task automatic t_fetch();
      cpu.set_fetch(24'h008100, 1'b1);
      acc(24'h008010, 2'h2, 1'b0, 1'b0, 32'h0);
      check(32'(stall_seen), 32'h1);
      cpu.set_fetch(24'h000100, 1'b1);
      acc(24'h008010, 2'h2, 1'b0, 1'b0, 32'h0);
      check(32'(stall_seen), 32'h0);
      acc(24'h000040, 2'h2, 1'b0, 1'b0, 32'h0);
      check(32'(stall_seen), 32'h1);
      cpu.set_fetch(24'h008000, 1'b0);
      $display("test fetch done");
   endtask : t_fetch

   task automatic t_vector();
      acc(bus_ctl_pkg::vector_base_high_addr, 2'h1, 1'b1, 1'b0, 32'h12);
      acc(bus_ctl_pkg::vector_base_low_addr, 2'h1, 1'b1, 1'b0, 32'h3456);
      check(32'(vector_base), 32'h123400);
      $display("test vector done");
   endtask : t_vector

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      @(negedge mclk);
      t_reset();
      t_waits();
      t_split();
      t_wide();
      t_fetch();
      t_vector();
      close_out();
   end

   // Whole run is well under a thousand cycles; this 20000-cycle margin only catches a hang
   initial
   begin
      #(8 * 20000);
      error_cnt++;
      close_out();
   end
endmodule : system_bus_access_control_tb
